/* logic/ast_defs.svh */
`ifndef AST_DEFS_SVH
`define AST_DEFS_SVH
// ==========================================================

// ==========================================================
// register offsets
`define AST_OFS_DATA   3'h0
`define AST_OFS_CSR_A  3'h1
`define AST_OFS_CSR_B  3'h2
`define AST_OFS_CSR_C  3'h3
`define AST_OFS_BAUD_L 3'h4
`define AST_OFS_BAUD_H 3'h5

// ==========================================================
// field positions
`define AST_A_RXC      7
`define AST_A_TXC      6
`define AST_A_U2X      1
`define AST_B_TXC_IE   6
`define AST_B_EMPTY_IE 5
`define AST_B_RX_EN    4
`define AST_B_TX_EN    3
`define AST_B_SIZE2    2
`define AST_B_TX_NINTH 0
`define AST_C_PAR_EN   5
`define AST_C_PAR_ODD  4
`define AST_C_TWO_STOP 3
`define AST_C_SIZE_HI  2
`define AST_C_SIZE_LO  1

// ==========================================================
// reset values and timing counts
`define AST_RST_SIZE   3'h3
`define AST_BAUD_W     12
`define AST_OVS_NORM   4'hF
`define AST_OVS_DBL    4'h7
`define AST_HALF_NORM  4'h7
`define AST_HALF_DBL   4'h3
`endif

/* logic/ast_pkg.sv */
`include "ast_defs.svh"
package ast_pkg;
    // ======================================================
    // register port request
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ast_bus_req_t;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} ast_rx_state_t;

    // ======================================================
    // baud generator state
    typedef struct packed {
        logic [`AST_BAUD_W-1:0] count;
        logic                   tick;
    } ast_baud_state_t;

    // ======================================================
    // serial block state
    typedef struct packed {
        logic [8:0]             tx_buf;
        logic                   tx_buf_full;
        logic [12:0]            tx_shift;
        logic [3:0]             tx_left;
        logic                   tx_busy;
        logic [3:0]             tx_pre;
        logic                   tx_on;
        logic                   txc;
        logic                   u2x;
        logic                   txc_ie;
        logic                   empty_ie;
        logic                   rx_en;
        logic                   tx_en_bit;
        logic                   tx_ninth;
        logic [2:0]             size;
        logic                   par_en;
        logic                   par_odd;
        logic                   two_stop;
        logic [`AST_BAUD_W-1:0] baud;
        ast_rx_state_t          rx_state;
        logic                   rx_sync1;
        logic                   rx_sync2;
        logic [3:0]             rx_cnt;
        logic [3:0]             rx_idx;
        logic [9:0]             rx_shift;
        logic [7:0]             rx_buf;
        logic                   rx_ninth;
        logic                   rx_full;
        logic [7:0]             rdata;
    } ast_state_t;
endpackage : ast_pkg

/* logic/ast_baud_gen.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ast_defs.svh"
module ast_baud_gen
    import ast_pkg::*;
(
    // clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    // divider setting
    input  wire logic [`AST_BAUD_W-1:0] divider,
    input  wire logic                   reload,
    // one-cycle tick at baud_clk rate
    output logic                        tick
);
    ast_baud_state_t s;
    ast_baud_state_t next_s;

    // ======================================================
    // down-counter, reload on zero or low divider byte write
    always_comb
    begin
        next_s = s;
        next_s.tick = 1'h0;
        if (reload)
        begin
            next_s.count = divider;
        end
        else if (s.count == '0)
        begin
            next_s.count = divider;
            next_s.tick = 1'h1;
        end
        else
        begin
            next_s.count = s.count - `AST_BAUD_W'(1);
        end
        if (rst)
        begin
            next_s = '0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        s <= next_s;
    end

    assign tick = s.tick;
endmodule : ast_baud_gen
`default_nettype wire

/* logic/ast_uart.sv */
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "ast_defs.svh"
module ast_uart
    import ast_pkg::*;
(
    // clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rst,
    // register port
    input  wire ast_bus_req_t  bus_req,
    output logic [7:0]         bus_rdata,
    // serial pins
    output logic               serial_out_pin,
    output logic               serial_out_oe,
    input  wire logic          serial_in_pin,
    output logic               rx_pin_owned,
    // interrupt requests
    output logic               tx_empty_irq,
    output logic               tx_done_irq,
    input  wire logic          tx_done_irq_ack
);
    ast_state_t s;
    ast_state_t next_s;

    logic        baud_tick;
    logic        baud_reload;
    logic [3:0]  nbits;
    logic [8:0]  mask;
    logic [12:0] frame;
    logic [3:0]  frame_len;
    logic        par_bit;
    logic        tx_tick;
    logic [3:0]  ovs_last;
    logic [3:0]  ovs_half;
    logic        rx_bit;
    logic        wr_data;
    logic        wr_a;
    logic        wr_b;
    logic        wr_c;
    logic        rd_data;

    // ======================================================
    // data bits per character
    function automatic logic [3:0] ast_nbits(input logic [2:0] code);
        logic [3:0] r;
        case (code)
            3'h0:    r = 4'h5;
            3'h1:    r = 4'h6;
            3'h2:    r = 4'h7;
            3'h7:    r = 4'h9;
            default: r = 4'h8;
        endcase
        return r;
    endfunction : ast_nbits

    // ======================================================
    // baud rate generator
    assign baud_reload = bus_req.wr && (bus_req.addr == `AST_OFS_BAUD_L);

    ast_baud_gen u_baud (
        .sys_clk (sys_clk),
        .rst     (rst),
        .divider (next_s.baud),
        .reload  (baud_reload),
        .tick    (baud_tick)
    );

    // ======================================================
    // decode and frame helpers
    always_comb
    begin
        wr_data = bus_req.wr && (bus_req.addr == `AST_OFS_DATA);
        wr_a = bus_req.wr && (bus_req.addr == `AST_OFS_CSR_A);
        wr_b = bus_req.wr && (bus_req.addr == `AST_OFS_CSR_B);
        wr_c = bus_req.wr && (bus_req.addr == `AST_OFS_CSR_C);
        rd_data = bus_req.rd && (bus_req.addr == `AST_OFS_DATA);
        nbits = ast_nbits(s.size);
        ovs_last = s.u2x ? `AST_OVS_DBL : `AST_OVS_NORM;
        ovs_half = s.u2x ? `AST_HALF_DBL : `AST_HALF_NORM;
        tx_tick = baud_tick && (s.tx_pre == ovs_last);
        rx_bit = s.rx_sync2;
        mask = '0;
        for (int i = 0; i < 9; i++)
        begin
            if (4'(i) < nbits)
            begin
                mask[i] = 1'h1;
            end
        end
        // frame: start, lsb-first data, parity, stop ones
        frame = '1;
        frame[0] = 1'h0;
        for (int i = 0; i < 9; i++)
        begin
            if (4'(i) < nbits)
            begin
                frame[i+1] = s.tx_buf[i];
            end
        end
        par_bit = (^s.tx_buf) ^ s.par_odd;
        if (s.par_en)
        begin
            frame[nbits+4'h1] = par_bit;
        end
        frame_len = 4'h2 + nbits + {3'h0, s.par_en} + {3'h0, s.two_stop};
    end

    // ======================================================
    // next state
    always_comb
    begin
        next_s = s;
        next_s.rdata = 8'h00;

        // pin synchroniser
        next_s.rx_sync1 = serial_in_pin;
        next_s.rx_sync2 = s.rx_sync1;

        // transmit bit-rate prescaler
        if (baud_tick)
        begin
            if (s.tx_pre == ovs_last)
            begin
                next_s.tx_pre = 4'h0;
            end
            else
            begin
                next_s.tx_pre = s.tx_pre + 4'h1;
            end
        end

        // status and control writes
        if (wr_a)
        begin
            next_s.u2x = bus_req.wdata[`AST_A_U2X];
            if (bus_req.wdata[`AST_A_TXC])
            begin
                next_s.txc = 1'h0;
            end
        end
        if (tx_done_irq_ack)
        begin
            next_s.txc = 1'h0;
        end
        if (wr_b)
        begin
            next_s.txc_ie = bus_req.wdata[`AST_B_TXC_IE];
            next_s.empty_ie = bus_req.wdata[`AST_B_EMPTY_IE];
            next_s.rx_en = bus_req.wdata[`AST_B_RX_EN];
            next_s.tx_en_bit = bus_req.wdata[`AST_B_TX_EN];
            next_s.size[2] = bus_req.wdata[`AST_B_SIZE2];
            next_s.tx_ninth = bus_req.wdata[`AST_B_TX_NINTH];
        end
        if (wr_c)
        begin
            next_s.par_en = bus_req.wdata[`AST_C_PAR_EN];
            next_s.par_odd = bus_req.wdata[`AST_C_PAR_ODD];
            next_s.two_stop = bus_req.wdata[`AST_C_TWO_STOP];
            next_s.size[1:0] = bus_req.wdata[`AST_C_SIZE_HI:`AST_C_SIZE_LO];
        end
        if (baud_reload)
        begin
            next_s.baud[7:0] = bus_req.wdata;
        end
        if (bus_req.wr && (bus_req.addr == `AST_OFS_BAUD_H))
        begin
            next_s.baud[`AST_BAUD_W-1:8] = bus_req.wdata[`AST_BAUD_W-9:0];
        end

        // transmitter pin ownership
        if (s.tx_en_bit)
        begin
            next_s.tx_on = 1'h1;
        end
        else if (!s.tx_busy && !s.tx_buf_full)
        begin
            next_s.tx_on = 1'h0;
        end

        // transmit shifter
        if (tx_tick && s.tx_on)
        begin
            if (s.tx_busy && (s.tx_left > 4'h1))
            begin
                next_s.tx_shift = {1'h1, s.tx_shift[12:1]};
                next_s.tx_left = s.tx_left - 4'h1;
            end
            else if (s.tx_buf_full)
            begin
                next_s.tx_shift = frame;
                next_s.tx_left = frame_len;
                next_s.tx_busy = 1'h1;
                next_s.tx_buf_full = 1'h0;
            end
            else
            begin
                if (s.tx_busy)
                begin
                    next_s.txc = 1'h1;
                end
                next_s.tx_busy = 1'h0;
                next_s.tx_left = 4'h0;
                next_s.tx_shift = '1;
            end
        end

        // transmit buffer load from data write
        if (wr_data)
        begin
            next_s.tx_buf = {s.tx_ninth, bus_req.wdata} & mask;
            next_s.tx_buf_full = 1'h1;
        end

        // receive buffer read
        if (rd_data)
        begin
            next_s.rx_full = 1'h0;
        end

        // receiver
        if (!s.rx_en)
        begin
            next_s.rx_state = RX_IDLE;
            next_s.rx_full = 1'h0;
            next_s.rx_cnt = 4'h0;
        end
        else if (baud_tick)
        begin
            case (s.rx_state)
                RX_IDLE:
                begin
                    if (!rx_bit)
                    begin
                        next_s.rx_state = RX_START;
                        next_s.rx_cnt = 4'h0;
                    end
                end
                RX_START:
                begin
                    if (s.rx_cnt == ovs_half)
                    begin
                        next_s.rx_cnt = 4'h0;
                        next_s.rx_idx = 4'h0;
                        if (!rx_bit)
                        begin
                            next_s.rx_state = RX_DATA;
                        end
                        else
                        begin
                            next_s.rx_state = RX_IDLE;
                        end
                    end
                    else
                    begin
                        next_s.rx_cnt = s.rx_cnt + 4'h1;
                    end
                end
                RX_DATA:
                begin
                    if (s.rx_cnt == ovs_last)
                    begin
                        next_s.rx_cnt = 4'h0;
                        if (s.rx_idx == (nbits + {3'h0, s.par_en}))
                        begin
                            next_s.rx_buf = s.rx_shift[7:0] & mask[7:0];
                            next_s.rx_ninth = s.rx_shift[8] & mask[8];
                            next_s.rx_full = 1'h1;
                            next_s.rx_state = RX_IDLE;
                        end
                        else
                        begin
                            next_s.rx_shift[s.rx_idx] = rx_bit;
                            next_s.rx_idx = s.rx_idx + 4'h1;
                        end
                    end
                    else
                    begin
                        next_s.rx_cnt = s.rx_cnt + 4'h1;
                    end
                end
                default:
                begin
                    next_s.rx_state = RX_IDLE;
                end
            endcase
        end

        // register read, answered next cycle
        if (bus_req.rd)
        begin
            case (bus_req.addr)
                `AST_OFS_DATA:
                begin
                    next_s.rdata = s.rx_buf;
                end
                `AST_OFS_CSR_A:
                begin
                    next_s.rdata = 8'h00;
                    next_s.rdata[`AST_A_RXC] = s.rx_full;
                    next_s.rdata[`AST_A_TXC] = s.txc;
                    next_s.rdata[5] = !s.tx_buf_full;
                    next_s.rdata[`AST_A_U2X] = s.u2x;
                end
                `AST_OFS_CSR_B:
                begin
                    next_s.rdata = {1'h0, s.txc_ie, s.empty_ie, s.rx_en,
                                    s.tx_en_bit, s.size[2], s.rx_ninth, s.tx_ninth};
                end
                `AST_OFS_CSR_C:
                begin
                    next_s.rdata = {2'h0, s.par_en, s.par_odd, s.two_stop,
                                    s.size[1:0], 1'h0};
                end
                `AST_OFS_BAUD_L:
                begin
                    next_s.rdata = s.baud[7:0];
                end
                `AST_OFS_BAUD_H:
                begin
                    next_s.rdata = {4'h0, s.baud[`AST_BAUD_W-1:8]};
                end
                default:
                begin
                    next_s.rdata = 8'h00;
                end
            endcase
        end

        // synchronous reset
        if (rst)
        begin
            next_s = '0;
            next_s.tx_shift = '1;
            next_s.size = `AST_RST_SIZE;
            next_s.rx_state = RX_IDLE;
            next_s.rx_sync1 = 1'h1;
            next_s.rx_sync2 = 1'h1;
        end
    end

    // ======================================================
    // state register
    always_ff @(posedge sys_clk)
    begin
        s <= next_s;
    end

    // ======================================================
    // outputs
    assign bus_rdata = s.rdata;
    assign serial_out_pin = s.tx_shift[0];
    assign serial_out_oe = s.tx_on;
    assign rx_pin_owned = s.rx_en;
    assign tx_empty_irq = s.empty_ie && !s.tx_buf_full;
    assign tx_done_irq = s.txc_ie && s.txc;
endmodule : ast_uart
`default_nettype wire

/* testbench/ast_uart_properties.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ast_defs.svh"
module ast_uart_props
    import ast_pkg::*;
(
    // clock and reset
    input wire logic         sys_clk,
    input wire logic         rst,
    // register port
    input wire ast_bus_req_t bus_req,
    input wire logic [7:0]   bus_rdata,
    // serial pins
    input wire logic         serial_out_pin,
    input wire logic         serial_out_oe,
    input wire logic         serial_in_pin,
    input wire logic         rx_pin_owned,
    // interrupt lines
    input wire logic         tx_empty_irq,
    input wire logic         tx_done_irq,
    input wire logic         tx_done_irq_ack
);
    // ==========
    // line and register relations
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_low_bit; serial_out_pin == 1'b0 [*8]; endsequence
    sequence s_high_bit; serial_out_pin == 1'b1 [*8]; endsequence
    property p_low_min; $fell(serial_out_pin) |-> s_low_bit; endproperty
    property p_high_min; $rose(serial_out_pin) |-> s_high_bit; endproperty
    property p_rdata_idle; !$past(bus_req.rd) |-> bus_rdata == 8'h00; endproperty
    property p_empty_clear; bus_req.wr && bus_req.addr == `AST_OFS_DATA |=> !tx_empty_irq; endproperty
    property p_ack_clear; tx_done_irq_ack |=> !tx_done_irq; endproperty
    property p_done_idle; $rose(tx_done_irq) |-> serial_out_pin && $past(serial_out_pin, 8); endproperty
    property p_oe_fall; $fell(serial_out_oe) |-> $past(serial_out_pin) && $past(serial_out_pin, 8); endproperty
    property p_rx_own;
        bus_req.wr && bus_req.addr == `AST_OFS_CSR_B |=> rx_pin_owned == $past(bus_req.wdata[`AST_B_RX_EN]);
    endproperty
    a_low_min: assert property (p_low_min)
        else $error("serial low shorter than a bit");
    a_high_min: assert property (p_high_min)
        else $error("serial high shorter than a bit");
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside its cycle");
    a_empty_clear: assert property (p_empty_clear)
        else $error("empty request after data write");
    a_ack_clear: assert property (p_ack_clear)
        else $error("done request survives service");
    a_done_idle: assert property (p_done_idle)
        else $error("done raised before stop bit ended");
    a_oe_fall: assert property (p_oe_fall)
        else $error("pin released mid frame");
    a_rx_own: assert property (p_rx_own)
        else $error("receive pin ownership wrong");
endmodule : ast_uart_props
`default_nettype wire

/* testbench/ast_remote_station.sv */
`timescale 1ns/10ps
`default_nettype none
module ast_remote_station
(
    // clock
    input  wire logic        sys_clk,
    // lines
    input  wire logic        tx_line,
    input  wire logic        tx_oe,
    output logic             rx_line,
    // frame format
    input  wire logic [3:0]  n_bits,
    input  wire logic        par_on,
    input  wire logic [15:0] bit_clks
);
    logic [9:0] got;
    int         got_cnt;
    initial
    begin
        rx_line = 1'b1;
        got_cnt = 0;
    end
    // ==========
    // frame capture, counted only with a high stop bit
    always
    begin
        @(negedge tx_line);
        got = '0;
        if (tx_oe === 1'b1)
        begin
            repeat (bit_clks / 2) @(posedge sys_clk);
            for (int i = 0; i < n_bits + par_on; i++)
            begin
                repeat (bit_clks) @(posedge sys_clk);
                got[i] = tx_line;
            end
            repeat (bit_clks) @(posedge sys_clk);
            if (tx_line === 1'b1)
                got_cnt++;
        end
    end
    // ==========
    // frame send, lsb first, two stop bits
    task automatic send(input logic [8:0] d, input int n);
        rx_line <= 1'b0;
        repeat (bit_clks) @(posedge sys_clk);
        for (int i = 0; i < n; i++)
        begin
            rx_line <= d[i];
            repeat (bit_clks) @(posedge sys_clk);
        end
        rx_line <= 1'b1;
        repeat (2 * bit_clks) @(posedge sys_clk);
    endtask : send
endmodule : ast_remote_station
`default_nettype wire

/* testbench/ast_uart_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ast_defs.svh"
bind ast_uart ast_uart_props u_props (.sys_clk(sys_clk), .rst(rst), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
    .serial_in_pin(serial_in_pin), .rx_pin_owned(rx_pin_owned), .tx_empty_irq(tx_empty_irq),
    .tx_done_irq(tx_done_irq), .tx_done_irq_ack(tx_done_irq_ack));
module ast_uart_tb
    import ast_pkg::*;
;
    // ==========
    // hookup
    logic sys_clk, rst, serial_out_pin, serial_out_oe, serial_in_pin, par_on;
    logic rx_pin_owned, tx_empty_irq, tx_done_irq, tx_done_irq_ack;
    ast_bus_req_t bus_req;
    logic [7:0] bus_rdata, rv;
    logic [3:0] n_bits;
    logic [15:0] bit_clks;
    int n_fail, check_count, nf;
    ast_uart dut (.sys_clk(sys_clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe), .serial_in_pin(serial_in_pin),
        .rx_pin_owned(rx_pin_owned), .tx_empty_irq(tx_empty_irq), .tx_done_irq(tx_done_irq),
        .tx_done_irq_ack(tx_done_irq_ack));
    ast_remote_station p (.sys_clk(sys_clk), .tx_line(serial_out_pin), .tx_oe(serial_out_oe),
        .rx_line(serial_in_pin), .n_bits(n_bits), .par_on(par_on), .bit_clks(bit_clks));
    // ==========
    // tasks
    task automatic chk(input string n, input logic [9:0] e, g);
        check_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("wrong value %s: expected %h, seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        bus_req.addr <= a;
        bus_req.wdata <= d;
        bus_req.wr <= 1'b1;
        @(posedge sys_clk);
        bus_req.wr <= 1'b0;
        @(posedge sys_clk);
    endtask : wr
    task automatic rchk(input string n, input logic [2:0] a, input logic [7:0] m, e);
        bus_req.addr <= a;
        bus_req.rd <= 1'b1;
        @(posedge sys_clk);
        bus_req.rd <= 1'b0;
        #1;
        rv = bus_rdata;
        @(posedge sys_clk);
        chk(n, {2'b00, e}, {2'b00, rv & m});
    endtask : rchk
    task automatic wait_frames(input int n);
        for (int i = 0; i < 8000 && p.got_cnt < n; i++)
            @(posedge sys_clk);
        chk("frame count", n[9:0], p.got_cnt[9:0]);
    endtask : wait_frames
    task automatic send_tx(input logic [7:0] d, input logic [9:0] e);
        wr(`AST_OFS_DATA, d);
        nf++;
        wait_frames(nf);
        chk("frame", e, p.got);
        for (int i = 0; i < 500 && tx_done_irq !== 1'b1; i++)
            @(posedge sys_clk);
        chk("done irq", 10'h001, {9'h000, tx_done_irq});
        tx_done_irq_ack <= 1'b1;
        @(posedge sys_clk);
        tx_done_irq_ack <= 1'b0;
        @(posedge sys_clk);
        chk("done irq", 10'h000, {9'h000, tx_done_irq});
    endtask : send_tx
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop
    // ==========
    // clock and watchdog
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial
    begin
        #300000;
        n_fail++;
        report_and_stop();
    end
    // ==========
    // tests
    initial
    begin
        rst = 1'b1;
        bus_req = '0;
        tx_done_irq_ack = 1'b0;
        n_bits = 4'h8;
        par_on = 1'b0;
        bit_clks = 16'd32;
        n_fail = 0;
        check_count = 0;
        nf = 0;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rchk("csr_a", `AST_OFS_CSR_A, 8'hFF, 8'h20);
        rchk("csr_b", `AST_OFS_CSR_B, 8'hFF, 8'h00);
        rchk("csr_c", `AST_OFS_CSR_C, 8'hFF, 8'h06);
        wr(3'h6, 8'h5A);
        rchk("unmapped", 3'h6, 8'hFF, 8'h00);
        $display("test reset values done");
        wr(`AST_OFS_BAUD_L, 8'h01);
        wr(`AST_OFS_BAUD_H, 8'h00);
        wr(`AST_OFS_CSR_B, 8'h78);
        @(posedge sys_clk);
        chk("out oe", 10'h001, {9'h000, serial_out_oe});
        chk("rx owned", 10'h001, {9'h000, rx_pin_owned});
        chk("empty irq", 10'h001, {9'h000, tx_empty_irq});
        send_tx(8'hA5, 10'h0A5);
        $display("test plain frame done");
        n_bits <= 4'h5;
        par_on <= 1'b1;
        for (int k = 0; k < 2; k++)
        begin
            wr(`AST_OFS_CSR_C, {3'b001, k[0], 4'h8});
            send_tx(8'hE6, {4'h0, (^5'h06) ^ k[0], 5'h06});
        end
        $display("test parity frames done");
        n_bits <= 4'h9;
        par_on <= 1'b0;
        wr(`AST_OFS_CSR_C, 8'h06);
        wr(`AST_OFS_CSR_B, 8'h7D);
        send_tx(8'h3C, 10'h13C);
        $display("test ninth bit done");
        n_bits <= 4'h8;
        wr(`AST_OFS_CSR_B, 8'h78);
        wr(`AST_OFS_DATA, 8'h11);
        for (int i = 0; i < 200 && tx_empty_irq !== 1'b1; i++)
            @(posedge sys_clk);
        chk("empty irq", 10'h001, {9'h000, tx_empty_irq});
        wr(`AST_OFS_DATA, 8'h22);
        rchk("csr_a", `AST_OFS_CSR_A, 8'h20, 8'h00);
        wr(`AST_OFS_CSR_B, 8'h70);
        chk("out oe", 10'h001, {9'h000, serial_out_oe});
        nf = nf + 2;
        wait_frames(nf);
        chk("frame", 10'h022, p.got);
        for (int i = 0; i < 400 && serial_out_oe !== 1'b0; i++)
            @(posedge sys_clk);
        chk("out oe", 10'h000, {9'h000, serial_out_oe});
        rchk("csr_a", `AST_OFS_CSR_A, 8'h40, 8'h40);
        wr(`AST_OFS_CSR_A, 8'h40);
        rchk("csr_a", `AST_OFS_CSR_A, 8'h40, 8'h00);
        $display("test back to back and disable done");
        p.send(9'h05A, 8);
        rchk("csr_a", `AST_OFS_CSR_A, 8'h80, 8'h80);
        rchk("rx data", `AST_OFS_DATA, 8'hFF, 8'h5A);
        rchk("csr_a", `AST_OFS_CSR_A, 8'h80, 8'h00);
        wr(`AST_OFS_CSR_A, 8'h02);
        wr(`AST_OFS_CSR_C, 8'h00);
        bit_clks <= 16'd16;
        @(posedge sys_clk);
        p.send(9'h1FF, 5);
        rchk("rx data", `AST_OFS_DATA, 8'hFF, 8'h1F);
        n_bits <= 4'h5;
        wr(`AST_OFS_CSR_B, 8'h78);
        send_tx(8'hF3, 10'h013);
        $display("test receive and double speed done");
        report_and_stop();
    end
endmodule : ast_uart_tb
`default_nettype wire
